// File: verilog/vc_cap_defs.svh
`ifndef VC_CAP_DEFS_SVH
`define VC_CAP_DEFS_SVH

// Register byte addresses inside the configuration space.
`define VC_OFS_HEADER 12'h140
`define VC_OFS_CAP_ONE 12'h144
`define VC_OFS_CAP_TWO 12'h148
`define VC_OFS_CTRL_STAT 12'h14C

// Header fields.
`define VC_EXT_CAP_ID 16'h0002
`define VC_CAP_VERSION 4'h1
`define VC_NEXT_CAP_PTR 12'h20C

// First port capability fields.
`define VC_EXT_COUNT 3'h0
`define VC_LP_COUNT_RESET 3'h0
`define VC_REF_CLOCK 2'h0
`define VC_TABLE_ENTRY_SIZE 2'h2

// Second port capability fields.
`define VC_ARB_CAPABILITY 8'h00
`define VC_ARB_TABLE_OFFSET 8'h00

// Control and status fields.
`define VC_CTRL_LOAD_BIT 0
`define VC_CTRL_SEL_LSB 1
`define VC_CTRL_SEL_MSB 3
`define VC_STAT_TABLE_BIT 16
`define VC_SEL_RESET 3'h0
`define VC_SEL_MAX_VALID 3'h1

// Time the hardware takes to apply a loaded table.
`define VC_LOAD_TIME_NS 64
`define VC_CLK_PERIOD_NS 8
`define VC_LOAD_CYCLES (`VC_LOAD_TIME_NS / `VC_CLK_PERIOD_NS)

`endif

// File: verilog/vc_cap_pkg.sv
package vc_cap_pkg;

    typedef enum logic [0:0] {
        LOAD_IDLE,
        LOAD_BUSY
    } load_state_e;

    typedef logic [2:0] arb_select_t;

endpackage : vc_cap_pkg

// File: verilog/pcie_vc_capability_regs.sv
// How it works
// (R1) The capability exists on the upstream port only; header at offset 140h.
// (R2) Header bits 15:0 read the fixed identifier 0002h and ignore writes.
// (R3) Header bits 19:16 read version 1, read-only.
// (R4) Header bits 31:20 read next pointer 20Ch, read-only.
// (R5) Extended channel count, bits 2:0 of capability one, reads zero.
// (R6) Low-priority count, bits 6:4, resets to zero, read-only to software.
// (R7) Low-priority count default may be overridden by the sideband loader.
// (R8) Reference clock field, bits 9:8, reads 00b for 100 ns.
// (R9) Table entry size field, bits 11:10, reads 10b for 4-bit entries.
// (R10) Arbitration capability, bits 7:0 of capability two, reads all zeros.
// (R11) Arbitration table offset, bits 31:24, reads zero, read-only.
// (R12) Writing one to control bit 0 loads the table; reads return zero.
// (R13) Select field bits 3:1 keeps 0 or 1; other values become default.
// (R14) Status bit 16 sets whenever software writes a table entry.
// (R15) Status bit 16 clears when the requested table load finishes.
// (R16) Writes to read-only or reserved fields do nothing; reserved read zero.
`timescale 1ns/10ps
`default_nettype none
`include "vc_cap_defs.svh"

module pcie_vc_capability_regs
    import vc_cap_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic UPSTREAM_PORT_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic LP_COUNT_LOAD_I,
    input wire logic [2:0] LP_COUNT_VALUE_I,
    input wire logic TABLE_ENTRY_WRITE_I,
    output logic [2:0] ARB_SELECT_O,
    output logic TABLE_LOAD_O
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Only the upper rule of the select field is needed: anything above
    // the highest supported scheme falls back to the default scheme.
    function automatic arb_select_t legal_select(input logic [2:0] value);
        if (value <= `VC_SEL_MAX_VALID) begin
            legal_select = value;
        end else begin
            legal_select = `VC_SEL_RESET;
        end
    endfunction : legal_select

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        hit = (addr[11:2] == ofs[11:2]);
    endfunction : hit

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Strap and sideband inputs come from outside the clock domain.
    logic upstream_meta;
    logic upstream_sync;
    logic lp_load_meta;
    logic lp_load_sync;
    logic lp_load_prev;
    logic entry_meta;
    logic entry_sync;
    logic entry_prev;
    logic [2:0] lp_value_meta;
    logic [2:0] lp_value_sync;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            upstream_meta <= 1'b0;
            upstream_sync <= 1'b0;
            lp_load_meta <= 1'b0;
            lp_load_sync <= 1'b0;
            lp_load_prev <= 1'b0;
            entry_meta <= 1'b0;
            entry_sync <= 1'b0;
            entry_prev <= 1'b0;
            lp_value_meta <= 3'h0;
            lp_value_sync <= 3'h0;
        end else begin
            upstream_meta <= UPSTREAM_PORT_I;
            upstream_sync <= upstream_meta;
            lp_load_meta <= LP_COUNT_LOAD_I;
            lp_load_sync <= lp_load_meta;
            lp_load_prev <= lp_load_sync;
            entry_meta <= TABLE_ENTRY_WRITE_I;
            entry_sync <= entry_meta;
            entry_prev <= entry_sync;
            lp_value_meta <= LP_COUNT_VALUE_I;
            lp_value_sync <= lp_value_meta;
        end
    end

    logic lp_load_pulse;
    logic entry_pulse;
    assign lp_load_pulse = lp_load_sync && !lp_load_prev;
    assign entry_pulse = entry_sync && !entry_prev;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Every access completes in its first access cycle.
    logic access;
    logic wr_access;
    logic cap_present;
    logic in_map;
    logic ctrl_write;

    assign access = PSEL_I && PENABLE_I;
    assign wr_access = access && PWRITE_I;
    assign cap_present = upstream_sync; // R1
    assign in_map = cap_present && (hit(PADDR_I, `VC_OFS_HEADER) ||
                    hit(PADDR_I, `VC_OFS_CAP_ONE) || hit(PADDR_I, `VC_OFS_CAP_TWO) ||
                    hit(PADDR_I, `VC_OFS_CTRL_STAT));
    assign ctrl_write = wr_access && cap_present && hit(PADDR_I, `VC_OFS_CTRL_STAT)
                        && PSTRB_I[0];
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access && !in_map;

    // ----------------------------------------------------------------
    // Low-priority channel count
    // ----------------------------------------------------------------
    // Software cannot write it; only the sideband loader changes it.
    logic [2:0] lp_count;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            lp_count <= `VC_LP_COUNT_RESET; // R6
        end else if (lp_load_pulse) begin
            lp_count <= lp_value_sync; // R7
        end
    end

    // ----------------------------------------------------------------
    // Arbitration select
    // ----------------------------------------------------------------
    arb_select_t arb_select;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            arb_select <= `VC_SEL_RESET;
        end else if (ctrl_write) begin
            arb_select <= legal_select(PWDATA_I[`VC_CTRL_SEL_MSB:`VC_CTRL_SEL_LSB]); // R13
        end
    end

    assign ARB_SELECT_O = arb_select;

    // ----------------------------------------------------------------
    // Table load sequencer
    // ----------------------------------------------------------------
    // The load bit is a write strobe only; nothing stores it.
    logic load_request;
    load_state_e load_state;
    logic [3:0] load_count;
    logic load_done;

    assign load_request = ctrl_write && PWDATA_I[`VC_CTRL_LOAD_BIT]; // R12
    assign load_done = (load_state == LOAD_BUSY) && (load_count == 4'h1);

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            load_state <= LOAD_IDLE;
            load_count <= 4'h0;
        end else begin
            case (load_state)
                LOAD_IDLE: begin
                    if (load_request) begin
                        load_state <= LOAD_BUSY; // R12
                        load_count <= 4'(`VC_LOAD_CYCLES);
                    end
                end
                LOAD_BUSY: begin
                    if (load_done) begin
                        load_state <= LOAD_IDLE;
                        load_count <= 4'h0;
                    end else begin
                        load_count <= load_count - 4'h1;
                    end
                end
                default: begin
                    load_state <= LOAD_IDLE;
                    load_count <= 4'h0;
                end
            endcase
        end
    end

    assign TABLE_LOAD_O = (load_state == LOAD_BUSY);

    // ----------------------------------------------------------------
    // Table status
    // ----------------------------------------------------------------
    // A new entry write in the finishing cycle leaves the bit set, so a
    // late edit is never reported as applied.
    logic table_status;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            table_status <= 1'b0;
        end else if (entry_pulse) begin
            table_status <= 1'b1; // R14
        end else if (load_done) begin
            table_status <= 1'b0; // R15
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000; // R16
        if (cap_present) begin
            if (hit(PADDR_I, `VC_OFS_HEADER)) begin
                next_rdata = {`VC_NEXT_CAP_PTR, `VC_CAP_VERSION, `VC_EXT_CAP_ID}; // R2 R3 R4
            end else if (hit(PADDR_I, `VC_OFS_CAP_ONE)) begin
                next_rdata = {20'h0_0000, `VC_TABLE_ENTRY_SIZE, `VC_REF_CLOCK, 1'b0,
                              lp_count, 1'b0, `VC_EXT_COUNT}; // R5 R6 R8 R9
            end else if (hit(PADDR_I, `VC_OFS_CAP_TWO)) begin
                next_rdata = {`VC_ARB_TABLE_OFFSET, 16'h0000, `VC_ARB_CAPABILITY}; // R10 R11
            end else if (hit(PADDR_I, `VC_OFS_CTRL_STAT)) begin
                next_rdata = {15'h0000, table_status, 12'h000, arb_select, 1'b0}; // R12 R14
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            PRDATA_O <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking chk_clk @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence load_write_s;
        ctrl_write && PWDATA_I[0] && (load_state == LOAD_IDLE);
    endsequence

    sequence load_run_s;
        TABLE_LOAD_O [*8] ##1 !TABLE_LOAD_O;
    endsequence

    header_read_a: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && cap_present
        && hit(PADDR_I, 12'h140) |=> PRDATA_O == 32'h20C1_0002) // R2
        else $error("Header read wrong.");
    version_read_a: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && cap_present
        && hit(PADDR_I, 12'h140) |=> PRDATA_O[19:16] == 4'h1) // R3
        else $error("Version wrong.");
    cap_one_a: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && cap_present
        && hit(PADDR_I, 12'h144) |=> PRDATA_O[11:8] == 4'h8 && PRDATA_O[2:0] == 3'h0) // R9
        else $error("Capability one fields wrong.");
    cap_two_a: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && cap_present
        && hit(PADDR_I, 12'h148) |=> PRDATA_O == 32'h0) // R10
        else $error("Capability two not zero.");
    ctrl_read_a: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && cap_present
        && hit(PADDR_I, 12'h14C) |=> PRDATA_O[0] == 1'b0 && PRDATA_O[31:17] == 15'h0) // R12
        else $error("Load bit or reserved bits read nonzero.");
    load_len_a: assert property (load_write_s |=> load_run_s) // R12
        else $error("Table load length wrong.");
    select_legal_a: assert property (ctrl_write && PWDATA_I[3:1] > 3'h1
        |=> ARB_SELECT_O == 3'h0) // R13
        else $error("Illegal select kept.");
    status_set_a: assert property (entry_pulse |=> table_status) // R14
        else $error("Status not set by entry write.");
    status_clear_a: assert property (load_done && !entry_pulse |=> !table_status) // R15
        else $error("Status not cleared after load.");
    absent_a: assert property (access && !cap_present |-> PSLVERR_O) // R1
        else $error("Access answered while capability absent.");

    // ----------------------------------------------------------------
    // Further checks
    // ----------------------------------------------------------------
    // The bus bench sees the sideband loader only through reads and never
    // drives the set-over-clear case or a cleared byte strobe, so they are
    // watched here cycle by cycle.

    sequence read_setup_s;
        PSEL_I && !PENABLE_I && !PWRITE_I;
    endsequence

    sequence lp_edge_s;
        lp_load_pulse;
    endsequence

    lp_load_a: assert property (lp_edge_s |=> lp_count == $past(lp_value_sync)) // R7
        else $error("Sideband count not loaded.");

    lp_hold_a: assert property (!lp_load_pulse |=> lp_count == $past(lp_count)) // R6
        else $error("Low-priority count changed without a load.");

    status_wins_a: assert property (entry_pulse && load_done |=> table_status) // R14
        else $error("Load completion cleared a fresh entry write.");

    status_hold_a: assert property (!entry_pulse && !load_done
        |=> table_status == $past(table_status)) // R14
        else $error("Status changed without an event.");

    select_keep_a: assert property (ctrl_write && PWDATA_I[3:1] <= 3'h1
        |=> ARB_SELECT_O == $past(PWDATA_I[3:1])) // R13
        else $error("Legal select not stored.");

    select_hold_a: assert property (!ctrl_write |=> $stable(ARB_SELECT_O)) // R13
        else $error("Select changed without a control write.");

    strobe_gate_a: assert property (wr_access && !PSTRB_I[0] |=> $stable(ARB_SELECT_O)) // R13
        else $error("Control write taken without its byte strobe.");

    load_busy_a: assert property (TABLE_LOAD_O && !load_done |=> TABLE_LOAD_O) // R12
        else $error("Table load stopped early.");

    load_idle_a: assert property (!TABLE_LOAD_O && !load_request |=> !TABLE_LOAD_O) // R12
        else $error("Table load started without a request.");

    load_count_a: assert property (TABLE_LOAD_O |-> load_count != 4'h0) // R12
        else $error("Load counter empty while loading.");

    error_map_a: assert property (access && cap_present && !in_map |-> PSLVERR_O) // R16
        else $error("Unmapped access not refused.");

    error_quiet_a: assert property (!access |-> !PSLVERR_O) // R16
        else $error("Slave error outside an access cycle.");

    mapped_ok_a: assert property (access && in_map |-> !PSLVERR_O) // R1
        else $error("Mapped access refused.");

    ready_a: assert property (PREADY_O) // R16
        else $error("Ready dropped.");

    absent_read_a: assert property (read_setup_s ##0 !cap_present
        |=> PRDATA_O == 32'h0000_0000) // R1
        else $error("Absent capability read nonzero.");

    status_read_a: assert property (read_setup_s ##0 cap_present && hit(PADDR_I, 12'h14C)
        |=> PRDATA_O[16] == $past(table_status)) // R14
        else $error("Status bit read wrong.");

    cap_one_lp_a: assert property (read_setup_s ##0 cap_present && hit(PADDR_I, 12'h144)
        |=> PRDATA_O[6:4] == $past(lp_count) && PRDATA_O[31:12] == 20'h0_0000) // R6
        else $error("Low-priority count read wrong.");

    prdata_hold_a: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I)
        |=> $stable(PRDATA_O)) // R16
        else $error("Read data changed outside a read setup.");

endmodule : pcie_vc_capability_regs

`default_nettype wire

// File: tb/test_pcie_vc_capability_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "vc_cap_defs.svh"

module test_pcie_vc_capability_regs;
    import vc_cap_pkg::*;

    // ------------------------------------------------------------
    // Clock, stimulus and design
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic upstream = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic lp_load = 1'b0;
    logic [2:0] lp_value = 3'h0;
    logic tbl_wr = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] arb_sel;
    logic tbl_load;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic er;

    always #4 clk_sys = ~clk_sys;

    pcie_vc_capability_regs dut (
        .CLK_SYS_I(clk_sys), .RST_I(rst), .UPSTREAM_PORT_I(upstream),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .LP_COUNT_LOAD_I(lp_load), .LP_COUNT_VALUE_I(lp_value),
        .TABLE_ENTRY_WRITE_I(tbl_wr), .ARB_SELECT_O(arb_sel), .TABLE_LOAD_O(tbl_load)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Request is held until pready is sampled high; data and error are taken at that edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            give_verdict();
        end
    endtask : apb

    task automatic read_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_er);
        apb(1'b0, a, 32'h0000_0000);
        check("read data", exp, rd);
        check("slave error", {31'h0, exp_er}, {31'h0, er});
    endtask : read_chk

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_values();
        read_chk(12'h140, 32'h20C1_0002, 1'b0);
        read_chk(12'h144, 32'h0000_0800, 1'b0);
        read_chk(12'h148, 32'h0000_0000, 1'b0);
        read_chk(12'h14C, 32'h0000_0000, 1'b0);
        check("select out", 32'h0, {29'h0, arb_sel});
        check("load out", 32'h0, {31'h0, tbl_load});
    endtask : reset_values

    task automatic read_only_writes();
        apb(1'b1, 12'h140, 32'hFFFF_FFFF);
        apb(1'b1, 12'h144, 32'hFFFF_FFFF);
        apb(1'b1, 12'h148, 32'hFFFF_FFFF);
        read_chk(12'h140, 32'h20C1_0002, 1'b0);
        read_chk(12'h144, 32'h0000_0800, 1'b0);
        read_chk(12'h148, 32'h0000_0000, 1'b0);
    endtask : read_only_writes

    task automatic select_codes();
        logic [2:0] s;
        for (int v = 0; v < 8; v++) begin
            s = (v <= 1) ? v[2:0] : 3'h0;
            apb(1'b1, 12'h14C, 32'hFFFF_FFF0 | (v << 1));
            read_chk(12'h14C, {28'h0, s, 1'b0}, 1'b0);
            check("select out", {29'h0, s}, {29'h0, arb_sel});
        end
    endtask : select_codes

    // A table entry write sets the status, then a load request clears it after 8 cycles.
    task automatic table_load();
        int n;
        n = 0;
        @(posedge clk_sys) tbl_wr <= 1'b1;
        repeat (6) @(posedge clk_sys);
        tbl_wr <= 1'b0;
        read_chk(12'h14C, 32'h0001_0000, 1'b0);
        apb(1'b1, 12'h14C, 32'h0000_0003);
        repeat (20) begin
            @(negedge clk_sys);
            if (tbl_load === 1'b1) n++;
        end
        check("load cycles", 32'd8, n);
        check("select out", 32'h1, {29'h0, arb_sel});
        read_chk(12'h14C, 32'h0000_0002, 1'b0);
    endtask : table_load

    task automatic lp_override();
        @(posedge clk_sys) lp_value <= 3'h5;
        repeat (4) @(posedge clk_sys);
        lp_load <= 1'b1;
        repeat (6) @(posedge clk_sys);
        lp_load <= 1'b0;
        read_chk(12'h144, 32'h0000_0850, 1'b0);
    endtask : lp_override

    task automatic refusals();
        read_chk(12'h150, 32'h0000_0000, 1'b1);
        @(posedge clk_sys) upstream <= 1'b0;
        repeat (4) @(posedge clk_sys);
        read_chk(12'h140, 32'h0000_0000, 1'b1);
        @(posedge clk_sys) upstream <= 1'b1;
        repeat (4) @(posedge clk_sys);
        read_chk(12'h140, 32'h20C1_0002, 1'b0);
    endtask : refusals

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        // The strap synchroniser needs two edges before the first access.
        repeat (3) @(posedge clk_sys);
        reset_values();
        read_only_writes();
        select_codes();
        table_load();
        lp_override();
        refusals();
        give_verdict();
    end

endmodule : test_pcie_vc_capability_regs

`default_nettype wire
